// ==== data_memory_space_decoder_tb_top.sv ====
`timescale 1ns/10ps
module data_memory_space_decoder_tb_top
   import dmd_pkg::*;
;
   logic clk_i = 1'b0, rst_b_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, cyc_en_i = 1'b0;
   logic xreq_i = 1'b0, xwe_i = 1'b0, xlag = 1'b0, ext_cyc_o, ext_we_o, xbusy_o, xdone_o, sfr_hit_o;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, xwdata_i = 8'h00, sfr_rdata_o, xrdata_o;
   logic [7:0] ext_rdata_i, ext_wdata_o;
   logic [15:0] xaddr_i = 16'h0000, ext_addr_o, a;
   logic [2:0] stretch_i = 3'h0, lock = 3'h0;
   logic [31:0] rs = 32'h23a226ee;
   int failures, samples_checked, map, cyc, sr [256], xm [int];
   int mv [6] = '{0, 1, 2, 3, 0, 1};
   logic [15:0] al [6] = '{16'h0000, 16'h00ff, 16'h0100, 16'hfffb, 16'hfffc, 16'hffff};
   dmd_decoder dmd_decoder_inst (.*, .security_lock_bits_i(lock), .p0_o(), .p0_oe_o(), .p2_o(),
      .p2_oe_o());
   dmd_ext_mem dmd_ext_mem_inst (.clk_i, .lag_i(xlag), .cyc_i(ext_cyc_o), .we_i(ext_we_o),
      .addr_i(ext_addr_o), .wdata_i(ext_wdata_o), .rdata_o(ext_rdata_i));
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) #1 cyc_en_i = (cyc++ % 4) == 0;
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pmc(input logic [7:0] ad, input logic [7:0] d);
      sfr_wr_i = 1'b1;
      sfr_addr_i = ad;
      sfr_wdata_i = d;
      @(posedge clk_i);
      #1 sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b1;
      sfr_addr_i = PMC_SFR_ADDR;
      if (ad == PMC_SFR_ADDR) map = d[1:0];
      #1 chk(sfr_rdata_o, {PMC_RESET[7:2], 2'(map)});
      chk({7'h00, sfr_hit_o}, 8'h01);
      @(posedge clk_i);
      #1 sfr_rd_i = 1'b0;
   endtask
   task automatic acc(input logic we);
      int n;
      logic ext, seen;
      logic [7:0] d, e;
      d = 8'(rnd());
      ext = map == 0 || (map == 1 && a > SRAM_TOP_ADDR);
      stretch_i = 3'(rnd());
      xlag = stretch_i > 3'h2;
      xreq_i = 1'b1;
      xwe_i = we;
      xaddr_i = a;
      xwdata_i = d;
      @(posedge clk_i);
      #1 xreq_i = 1'b0;
      n = 0;
      seen = 1'b0;
      while (xdone_o !== 1'b1 && n < 200) begin
         seen |= ext_cyc_o;
         n++;
         @(posedge clk_i);
         #1;
      end
      if (ext) e = 8'(xm[a]);
      else if (map[0] && a <= SRAM_TOP_ADDR) e = 8'(sr[a]);
      else if (map == 3 && a == LOCK_STATUS_ADDR) e = {5'h00, lock};
      else e = 8'h00;
      if (we && ext) xm[a] = d;
      else if (we && map[0] && a <= SRAM_TOP_ADDR) sr[a] = d;
      else if (!we) chk(xrdata_o, e);
      chk({7'h00, seen}, {7'h00, ext});
      chk({7'h00, xdone_o}, 8'h01);
      @(posedge clk_i);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      lock = 3'(rnd());
      repeat (10) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 pmc(8'hc5, 8'h03);
      foreach (mv[i]) begin
         pmc(PMC_SFR_ADDR, {6'(rnd()), 2'(mv[i])});
         for (int j = 0; j < 7; j++) begin
            a = j < 6 ? al[j] : 16'(rnd());
            acc(1'b1);
            acc(1'b0);
         end
         $display("test %0d done", i);
      end
      report_and_stop();
   end
   initial begin
      #2000000;
      failures++;
      report_and_stop();
   end
endmodule

// ==== dmd_decoder.sv ====
`timescale 1ns/10ps
module dmd_decoder
   import dmd_pkg::*;
#(
   parameter int SW = STRETCH_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Special function register port
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   // External data move request from the core, one per instruction cycle enable
   input wire logic cyc_en_i,
   input wire logic xreq_i,
   input wire logic xwe_i,
   input wire logic [15:0] xaddr_i,
   input wire logic [7:0] xwdata_i,
   input wire logic [SW-1:0] stretch_i,
   output logic xbusy_o,
   output logic xdone_o,
   output logic [7:0] xrdata_o,
   // Lock fuse levels
   input wire logic [2:0] security_lock_bits_i,
   // Multiplexed port 0 / port 2 bus
   output logic ext_cyc_o,
   output logic ext_we_o,
   output logic [15:0] ext_addr_o,
   output logic [7:0] ext_wdata_o,
   input wire logic [7:0] ext_rdata_i,
   output logic [7:0] p0_o,
   output logic p0_oe_o,
   output logic [7:0] p2_o,
   output logic p2_oe_o
);
   typedef enum logic [1:0] {
      DMD_ST_IDLE = 2'b00,
      DMD_ST_RUN = 2'b01,
      DMD_ST_DONE = 2'b10
   } dmd_st_t;

   // Both live maps share the same low window of 256 bytes
   function automatic logic in_sram_window(input logic [15:0] a);
      return a <= SRAM_TOP_ADDR;
   endfunction

   // Register select shared by the write path and the read-back path
   function automatic logic pmc_sel(input logic [7:0] a);
      return a == PMC_SFR_ADDR;
   endfunction

   // Lock status byte: one bit per programmed fuse, upper bits read zero
   function automatic logic [7:0] lock_byte(input logic [2:0] bits);
      return {5'h00, bits};
   endfunction

   // Access length in instruction cycles; stretch only ever applies off chip
   function automatic logic [SW:0] access_len(input dmd_tgt_t t, input logic [SW-1:0] s);
      logic [SW:0] n;
      n = (SW+1)'(INT_ACCESS_CYCLES);
      if (t == DMD_TGT_EXT) begin
         n = n + {1'b0, s};
      end
      return n;
   endfunction

   function automatic dmd_tgt_t decode(input logic [1:0] map, input logic [15:0] a);
      dmd_tgt_t t;
      t = DMD_TGT_EXT;
      unique case (map)
         DMD_MAP_EXT: t = DMD_TGT_EXT;
         DMD_MAP_INT: begin
            if (in_sram_window(a)) begin
               t = DMD_TGT_SRAM;
            end else begin
               t = DMD_TGT_EXT;
            end
         end
         DMD_MAP_RSV: t = DMD_TGT_NONE;
         DMD_MAP_LCK: begin
            // Only the status byte answers up high; the rest of that space is dead
            if (in_sram_window(a)) begin
               t = DMD_TGT_SRAM;
            end else if (a == LOCK_STATUS_ADDR) begin
               t = DMD_TGT_LOCK;
            end else begin
               t = DMD_TGT_NONE;
            end
         end
      endcase
      return t;
   endfunction

   // Power management control register
   logic [7:0] pmc_q, pmc_d;

   always_comb begin
      pmc_d = pmc_q;
      if (sfr_wr_i && pmc_sel(sfr_addr_i)) begin
         // Only the enable field is writable here; other bits belong elsewhere
         pmc_d = (pmc_q & ~PMC_WR_MASK) | (sfr_wdata_i & PMC_WR_MASK);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pmc_q <= PMC_RESET;
      end else begin
         pmc_q <= pmc_d;
      end
   end

   // Fuse levels are asynchronous to the core clock: two flops before any use
   logic [2:0] lock_s1_q, lock_s1_d;
   logic [2:0] lock_s2_q, lock_s2_d;

   always_comb begin
      lock_s1_d = security_lock_bits_i;
      lock_s2_d = lock_s1_q;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_s1_q <= 3'h0;
         lock_s2_q <= 3'h0;
      end else begin
         lock_s1_q <= lock_s1_d;
         lock_s2_q <= lock_s2_d;
      end
   end

   logic [1:0] map;
   assign map = {pmc_q[PMC_EN_HI_BIT], pmc_q[PMC_EN_LO_BIT]};
   assign sfr_hit_o = sfr_rd_i && pmc_sel(sfr_addr_i);
   assign sfr_rdata_o = sfr_hit_o ? pmc_q : 8'h00;

   // Access sequencer
   dmd_st_t st_q, st_d;
   dmd_tgt_t tgt_q, tgt_d;
   logic [SW:0] cnt_q, cnt_d;
   logic we_q, we_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] wdata_q, wdata_d;
   dmd_mem_if mif ();

   always_comb begin
      st_d = st_q;
      tgt_d = tgt_q;
      cnt_d = cnt_q;
      we_d = we_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      unique case (st_q)
         // Requests while busy are simply not looked at
         DMD_ST_IDLE: begin
            if (xreq_i) begin
               // Live map sampled at request time
               tgt_d = decode(map, xaddr_i);
               we_d = xwe_i;
               addr_d = xaddr_i;
               wdata_d = xwdata_i;
               cnt_d = access_len(tgt_d, stretch_i);
               st_d = DMD_ST_RUN;
            end
         end
         DMD_ST_RUN: begin
            if (cyc_en_i) begin
               cnt_d = cnt_q - (SW+1)'(1);
               if (cnt_q == (SW+1)'(1)) begin
                  st_d = DMD_ST_DONE;
               end
            end
         end
         DMD_ST_DONE: st_d = DMD_ST_IDLE;
         default: st_d = DMD_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= DMD_ST_IDLE;
         tgt_q <= DMD_TGT_NONE;
         cnt_q <= '0;
         we_q <= 1'b0;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
      end else begin
         st_q <= st_d;
         tgt_q <= tgt_d;
         cnt_q <= cnt_d;
         we_q <= we_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
      end
   end

   // Read data register: loads once per completed read, writes leave it alone
   logic [7:0] rdata_q, rdata_d;
   logic last_step;
   assign last_step = (st_q == DMD_ST_RUN) && cyc_en_i && (cnt_q == (SW+1)'(1));

   always_comb begin
      rdata_d = rdata_q;
      // Suppressed reads return zero rather than whatever floats on the bus
      if (last_step && !we_q) begin
         unique case (tgt_q)
            DMD_TGT_SRAM: rdata_d = mif.rdata;
            DMD_TGT_EXT: rdata_d = ext_rdata_i;
            DMD_TGT_LOCK: rdata_d = lock_byte(lock_s2_q);
            DMD_TGT_NONE: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // SRAM port: enabled on every clock of the run until the first enabled cycle, data held in the memory register
   assign mif.en = (st_q == DMD_ST_RUN) && (tgt_q == DMD_TGT_SRAM)
      && (cnt_q == (SW+1)'(INT_ACCESS_CYCLES));
   assign mif.we = we_q;
   assign mif.addr = addr_q[7:0];
   assign mif.wdata = wdata_q;

   dmd_sram #(.DEPTH(SRAM_DEPTH)) u_sram (
      .clk_i(clk_i),
      .bus(mif.mem)
   );

   // Port drivers are flops loaded from the next state, so pins settle together with it
   logic ext_act_q, ext_act_d;
   logic ext_we_q, ext_we_d;
   logic [7:0] p0_q, p0_d;
   logic [7:0] p2_q, p2_d;

   always_comb begin
      ext_act_d = (st_d == DMD_ST_RUN) && (tgt_d == DMD_TGT_EXT);
      ext_we_d = ext_act_d && we_d;
      p2_d = addr_d[15:8];
      // Port 0 carries write data during an external write, the low address otherwise
      if (ext_we_d) begin
         p0_d = wdata_d;
      end else begin
         p0_d = addr_d[7:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ext_act_q <= 1'b0;
         ext_we_q <= 1'b0;
         p0_q <= 8'h00;
         p2_q <= 8'h00;
      end else begin
         ext_act_q <= ext_act_d;
         ext_we_q <= ext_we_d;
         p0_q <= p0_d;
         p2_q <= p2_d;
      end
   end

   // Suppressed and lock targets never raise the external strobe
   assign ext_cyc_o = ext_act_q;
   assign ext_we_o = ext_we_q;
   assign ext_addr_o = addr_q;
   assign ext_wdata_o = wdata_q;
   assign p2_o = p2_q;
   assign p2_oe_o = ext_act_q;
   assign p0_o = p0_q;
   assign p0_oe_o = ext_act_q;

   assign xbusy_o = (st_q != DMD_ST_IDLE);
   assign xdone_o = (st_q == DMD_ST_DONE);
   assign xrdata_o = rdata_q;
endmodule

// ==== dmd_decoder_properties.sv ====
`timescale 1ns/10ps
module dmd_decoder_props
   import dmd_pkg::*;
#(
   parameter int SW = STRETCH_W
) (
   // Watched design ports
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic cyc_en_i,
   input wire logic xreq_i,
   input wire logic xwe_i,
   input wire logic [15:0] xaddr_i,
   input wire logic [SW-1:0] stretch_i,
   input wire logic xbusy_o,
   input wire logic xdone_o,
   input wire logic [7:0] xrdata_o,
   input wire logic [2:0] security_lock_bits_i,
   input wire logic ext_cyc_o,
   input wire logic ext_we_o,
   input wire logic [15:0] ext_addr_o,
   input wire logic [7:0] ext_wdata_o,
   input wire logic sfr_hit_o,
   input wire logic [7:0] p0_o,
   input wire logic p0_oe_o,
   input wire logic [7:0] p2_o,
   input wire logic p2_oe_o
);
   logic [1:0] map_q, map_d;
   logic [7:0] cnt_q, cnt_d;
   logic [SW-1:0] st_q, st_d;
   logic int_q, int_d, lk_q, lk_d, rz_q, rz_d;
   wire take = xreq_i && !xbusy_o;
   wire lo = xaddr_i <= SRAM_TOP_ADDR;
   wire inr = map_q != DMD_MAP_EXT && !(map_q == DMD_MAP_INT && !lo);
   always_comb begin
      map_d = (sfr_wr_i && sfr_addr_i == PMC_SFR_ADDR) ? sfr_wdata_i[1:0] : map_q;
      // Only enabled cycles inside the run state count towards the access length
      cnt_d = take ? 8'h00 : cnt_q + {7'h00, xbusy_o && !xdone_o && cyc_en_i};
      st_d = take ? stretch_i : st_q;
      int_d = take ? inr : int_q;
      lk_d = take ? (map_q == DMD_MAP_LCK && xaddr_i == LOCK_STATUS_ADDR && !xwe_i) : lk_q;
      rz_d = take ? (inr && !xwe_i && !lk_d && (map_q == DMD_MAP_RSV || !lo)) : rz_q;
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {map_q, cnt_q, st_q, int_q, lk_q, rz_q} <= '0;
      end else begin
         {map_q, cnt_q, st_q, int_q, lk_q, rz_q} <= {map_d, cnt_d, st_d, int_d, lk_d, rz_d};
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_ext; take && map_q == DMD_MAP_EXT |=> ext_cyc_o; endproperty
   a_ext: assert property (p_ext) else $error("no external cycle");
   property p_high; take && map_q == DMD_MAP_INT && !lo |=> ext_cyc_o; endproperty
   a_high: assert property (p_high) else $error("high address not external");
   property p_quiet; take && inr |=> !ext_cyc_o [*3]; endproperty
   a_quiet: assert property (p_quiet) else $error("unexpected external cycle");
   property p_two; xdone_o && int_q |-> cnt_q == 8'h02; endproperty
   a_two: assert property (p_two) else $error("internal access length wrong");
   property p_str; xdone_o && !int_q |-> int'(cnt_q) == 2 + int'(st_q); endproperty
   a_str: assert property (p_str) else $error("stretched length wrong");
   property p_lock; xdone_o && lk_q |-> xrdata_o == {5'h00, security_lock_bits_i}; endproperty
   a_lock: assert property (p_lock) else $error("lock status wrong");
   property p_zero; xdone_o && rz_q |-> xrdata_o == 8'h00; endproperty
   a_zero: assert property (p_zero) else $error("suppressed read not zero");
   property p_pmc; sfr_rd_i && sfr_addr_i == PMC_SFR_ADDR |-> sfr_rdata_o == {PMC_RESET[7:2], map_q};
   endproperty
   a_pmc: assert property (p_pmc) else $error("enable field readback wrong");
   property p_pins; ext_cyc_o |-> p0_oe_o && p2_oe_o && p2_o == ext_addr_o[15:8]
      && p0_o == (ext_we_o ? ext_wdata_o : ext_addr_o[7:0]); endproperty
   a_pins: assert property (p_pins) else $error("port bus wrong during external cycle");
   property p_float; !ext_cyc_o |-> !p0_oe_o && !p2_oe_o && !ext_we_o; endproperty
   a_float: assert property (p_float) else $error("port driven outside external cycle");
   property p_hit; sfr_rd_i && sfr_addr_i == PMC_SFR_ADDR |-> sfr_hit_o; endproperty
   a_hit: assert property (p_hit) else $error("register read not claimed");
endmodule
bind dmd_decoder dmd_decoder_props #(.SW(SW)) dmd_decoder_props_inst (.*);

// ==== dmd_ext_mem.sv ====
`timescale 1ns/10ps
module dmd_ext_mem (
   // Multiplexed bus from the decoder
   input wire logic clk_i,
   input wire logic lag_i,
   input wire logic cyc_i,
   input wire logic we_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [65536];
   logic [7:0] last_q = 8'h00;
   int age = 0;
   // Slow part answers late; a released bus toggles so stale data never looks valid
   assign rdata_o = (cyc_i && !we_i && age >= 6 * lag_i) ? mem[addr_i] : ~last_q;
   always @(posedge clk_i) begin
      age <= cyc_i ? age + 1 : 0;
      last_q <= rdata_o;
      if (cyc_i && we_i) mem[addr_i] <= wdata_i;
   end
endmodule

// ==== dmd_mem_if.sv ====
`timescale 1ns/10ps
interface dmd_mem_if;
   logic en;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output en, output we, output addr, output wdata, input rdata);
   modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// ==== dmd_pkg.sv ====
package dmd_pkg;
   localparam logic [7:0] PMC_SFR_ADDR = 8'hc4;
   localparam int PMC_EN_LO_BIT = 0;
   localparam int PMC_EN_HI_BIT = 1;
   localparam logic [7:0] PMC_RESET = 8'h40;
   localparam logic [7:0] PMC_WR_MASK = 8'h03;
   localparam logic [15:0] LOCK_STATUS_ADDR = 16'hfffc;
   localparam logic [15:0] SRAM_TOP_ADDR = 16'h00ff;
   localparam int LOCK_STATUS_BIT0 = 0;
   localparam int SRAM_DEPTH = 256;
   localparam int INT_ACCESS_CYCLES = 2;
   localparam int STRETCH_W = 3;

   typedef enum logic [1:0] {
      DMD_MAP_EXT = 2'b00,
      DMD_MAP_INT = 2'b01,
      DMD_MAP_RSV = 2'b10,
      DMD_MAP_LCK = 2'b11
   } dmd_map_t;

   typedef enum logic [1:0] {
      DMD_TGT_EXT = 2'b00,
      DMD_TGT_SRAM = 2'b01,
      DMD_TGT_LOCK = 2'b10,
      DMD_TGT_NONE = 2'b11
   } dmd_tgt_t;
endpackage

// ==== dmd_sram.sv ====
`timescale 1ns/10ps
module dmd_sram
   import dmd_pkg::*;
#(
   parameter int DEPTH = SRAM_DEPTH
) (
   input wire logic clk_i,
   dmd_mem_if.mem bus
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] rdata_q;

   // Contents not reset: battery-backed storage keeps its data
   always_ff @(posedge clk_i) begin
      if (bus.en) begin
         if (bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
         end
         rdata_q <= mem_q[bus.addr];
      end
   end

   assign bus.rdata = rdata_q;
endmodule
